// [logic/sac_pkg.sv]
// Shared constants, types and helpers for the serial ADC command block.
`default_nettype none

package sac_pkg;

    // Clock rate and typical conversion times.
    localparam real CLOCK_MHZ    = 125.0;
    localparam real TEMP_CONV_MS = 2.2;
    localparam real VOLT_CONV_MS = 1.1;
    localparam int  TEMP_CONV_CYCLES = int'(TEMP_CONV_MS * 1000.0 * CLOCK_MHZ);
    localparam int  VOLT_CONV_CYCLES = int'(VOLT_CONV_MS * 1000.0 * CLOCK_MHZ);
    localparam int  CONV_COUNT_W     = 19;

    // Serial framing.
    localparam logic [2:0] RX_LAST_BIT    = 3'h6;
    localparam logic [4:0] OUT_COUNT_DONE = 5'h10;
    localparam logic [4:0] OUT_COUNT_MSB  = 5'h00;

    // Byte patterns and field positions.
    localparam logic [7:0] CFG_MASK   = 8'h78;
    localparam logic [7:0] CFG_MATCH  = 8'h00;
    localparam logic [7:0] CONV_MASK  = 8'h70;
    localparam logic [7:0] CONV_MATCH = 8'h20;
    localparam int         PM_MSB     = 2;
    localparam int         PM_LSB     = 1;
    localparam int         REF_BIT    = 0;
    localparam int         SEL_MSB    = 3;

    typedef enum logic [1:0] {
        SAC_PM_SHUTDOWN     = 2'h0,
        SAC_PM_STANDBY_PLUS = 2'h1,
        SAC_PM_STANDBY      = 2'h2,
        SAC_PM_NORMAL       = 2'h3
    } sac_power_e;

    // Input selections that measure a diode temperature.
    localparam logic [3:0] SEL_INT_DIODE  = 4'h7;
    localparam logic [3:0] SEL_EXT_DIODE1 = 4'hC;
    localparam logic [3:0] SEL_EXT_DIODE2 = 4'hD;

    // Values after reset.
    localparam logic [1:0]  POWER_MODE_RESET = 2'h0;
    localparam logic        REF_SEL_RESET    = 1'b0;
    localparam logic [3:0]  SELECT_RESET     = 4'h0;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;

    typedef enum logic [2:0] {
        SAC_RX_HUNT  = 3'b001,
        SAC_RX_SHIFT = 3'b010,
        SAC_RX_HOLD  = 3'b100
    } sac_rx_state_e;

    typedef enum logic [1:0] {
        SAC_CV_IDLE = 2'b01,
        SAC_CV_RUN  = 2'b10
    } sac_conv_state_e;

    function automatic logic sac_is_temp(input logic [3:0] sel);
        sac_is_temp = (sel == SEL_INT_DIODE) || (sel == SEL_EXT_DIODE1)
                   || (sel == SEL_EXT_DIODE2);
    endfunction : sac_is_temp

endpackage : sac_pkg

`default_nettype wire

// [logic/sac_sync.sv]
// Three-stage synchroniser that passes a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            syncOut <= '0;
        else
            syncOut <= (stage3_reg & ~(stage2_reg ^ stage3_reg))
                     | (syncOut & (stage2_reg ^ stage3_reg));
    end

endmodule : sac_sync

`default_nettype wire

// [logic/sac_serial_adc.sv]
// Serial command decode, conversion sequencing and result readout.
`timescale 1ns/1ps
`default_nettype none

module sac_serial_adc
    import sac_pkg::*;
#(
    parameter int TEMP_CYCLES = TEMP_CONV_CYCLES,
    parameter int VOLT_CYCLES = VOLT_CONV_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        linkClock,
    input  wire logic        chipSelectN,
    input  wire logic        serialIn,
    output logic             serialOut,
    output logic             serialOutEn,
    output logic             conversionStrobe,
    input  wire logic [11:0] adcTempCode,
    input  wire logic [9:0]  adcVoltCode,
    input  wire logic [2:0]  adcSubBits,
    output logic [1:0]       powerMode,
    output logic             internalRefEn,
    output logic [3:0]       inputSelect,
    output logic             converting
);

    // Link side, clocked by the shift clock.
    logic                    linkRst_n;
    sac_rx_state_e           rxState_reg;
    logic [2:0]              rxBits_reg;
    logic [6:0]              rxShift_reg;
    logic                    convReqPos_reg;
    logic [7:0]              rxByte;
    logic                    byteDone;
    logic                    cfgByte;
    logic                    convByte;
    logic [1:0]              linkPowerMode_reg;
    logic                    linkRef_reg;
    logic [3:0]              linkSelect_reg;
    logic                    cfgToggle_reg;
    logic                    convToggle_reg;
    logic [4:0]              outCount_reg;

    // Core side, clocked by the internal clock.
    logic [1:0]              toggleSync;
    logic [1:0]              togglePrev_reg;
    logic                    cfgEvent;
    logic                    convEvent;
    sac_conv_state_e         convState_reg;
    logic [CONV_COUNT_W-1:0] convCount_reg;
    logic                    convTemp_reg;
    logic                    convDone;
    logic                    strobe_reg;
    logic [1:0]              powerMode_reg;
    logic                    refSelect_reg;
    logic [3:0]              inputSelect_reg;
    logic [15:0]             resultWord_reg;
    logic [CONV_COUNT_W-1:0] lowCount_reg;
    logic                    cfgSeen_reg;

    // Raising select resets the receiver, so no bit is taken then.
    assign linkRst_n = reset_n & ~chipSelectN;
    assign rxByte    = {rxShift_reg, serialIn};
    assign byteDone  = (rxState_reg == SAC_RX_SHIFT)
                    && (rxBits_reg == RX_LAST_BIT);
    assign cfgByte   = byteDone
                    && ((rxByte & CFG_MASK) == CFG_MATCH);
    assign convByte  = byteDone
                    && ((rxByte & CONV_MASK) == CONV_MATCH);

    always_ff @(posedge linkClock or negedge linkRst_n)
    begin
        if (!linkRst_n)
        begin
            rxState_reg <= SAC_RX_HUNT;
            rxBits_reg  <= 3'h0;
            rxShift_reg <= 7'h00;
        end
        else
        begin
            unique case (rxState_reg)
                SAC_RX_HUNT:
                begin
                    if (serialIn)
                    begin
                        rxState_reg <= SAC_RX_SHIFT;
                        rxBits_reg  <= 3'h0;
                        rxShift_reg <= 7'h01;
                    end
                end
                SAC_RX_SHIFT:
                begin
                    rxShift_reg <= {rxShift_reg[5:0], serialIn};
                    rxBits_reg  <= rxBits_reg + 3'h1;
                    if (byteDone)
                    begin
                        if (convByte)
                            rxState_reg <= SAC_RX_HOLD;
                        else
                            rxState_reg <= SAC_RX_HUNT;
                    end
                end
                SAC_RX_HOLD:
                begin
                    if (outCount_reg == OUT_COUNT_DONE && !convReqPos_reg)
                        rxState_reg <= SAC_RX_HUNT;
                end
            endcase
        end
    end

    // Held for one shift period so exactly one falling edge sees it.
    always_ff @(posedge linkClock or negedge linkRst_n)
    begin
        if (!linkRst_n)
            convReqPos_reg <= 1'b0;
        else
            convReqPos_reg <= convByte;
    end

    // Settings survive select going high; only reset clears them.
    always_ff @(posedge linkClock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            linkPowerMode_reg <= POWER_MODE_RESET;
            linkRef_reg       <= REF_SEL_RESET;
            cfgToggle_reg     <= 1'b0;
        end
        else if (cfgByte && !chipSelectN)
        begin
            linkPowerMode_reg <= rxByte[PM_MSB:PM_LSB];
            linkRef_reg       <= rxByte[REF_BIT];
            cfgToggle_reg     <= ~cfgToggle_reg;
        end
    end

    always_ff @(posedge linkClock or negedge reset_n)
    begin
        if (!reset_n)
            linkSelect_reg <= SELECT_RESET;
        else if (convByte && !chipSelectN)
            linkSelect_reg <= rxByte[SEL_MSB:0];
    end

    // Falling edges: start the conversion, then walk the result out.
    always_ff @(negedge linkClock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            convToggle_reg <= 1'b0;
            outCount_reg   <= OUT_COUNT_DONE;
        end
        else if (convReqPos_reg && !chipSelectN)
        begin
            convToggle_reg <= ~convToggle_reg;
            outCount_reg   <= OUT_COUNT_MSB;
        end
        else if (!chipSelectN && outCount_reg != OUT_COUNT_DONE)
            outCount_reg <= outCount_reg + 5'h01;
    end

    // The result word only changes while the count is parked at zero or at OUT_COUNT_DONE,
    // so reading it from the shift-clock side is safe.
    always_comb
    begin
        if (outCount_reg == OUT_COUNT_DONE)
            serialOut = 1'b0;
        else
            serialOut = resultWord_reg[~outCount_reg[3:0]];
    end

    assign serialOutEn = ~chipSelectN;

    sac_sync #(
        .WIDTH (2)
    ) u_toggleSync (
        .clock   (clock),
        .reset_n (reset_n),
        .asyncIn ({cfgToggle_reg, convToggle_reg}),
        .syncOut (toggleSync)
    );

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            togglePrev_reg <= 2'h0;
        else
            togglePrev_reg <= toggleSync;
    end

    assign cfgEvent  = toggleSync[1] ^ togglePrev_reg[1];
    assign convEvent = toggleSync[0] ^ togglePrev_reg[0];
    assign convDone  = (convState_reg == SAC_CV_RUN)
                    && (convCount_reg == '0);

    // A conversion byte alone keeps the last power and reference setup.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerMode_reg <= POWER_MODE_RESET;
            refSelect_reg <= REF_SEL_RESET;
        end
        else if (cfgEvent)
        begin
            powerMode_reg <= linkPowerMode_reg;
            refSelect_reg <= linkRef_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            convState_reg   <= SAC_CV_IDLE;
            convCount_reg   <= '0;
            convTemp_reg    <= 1'b0;
            inputSelect_reg <= SELECT_RESET;
        end
        else
        begin
            unique case (convState_reg)
                SAC_CV_IDLE:
                begin
                    if (convEvent)
                    begin
                        convState_reg   <= SAC_CV_RUN;
                        inputSelect_reg <= linkSelect_reg;
                        convTemp_reg    <= sac_is_temp(linkSelect_reg);
                        if (sac_is_temp(linkSelect_reg))
                            convCount_reg <=
                                CONV_COUNT_W'(TEMP_CYCLES - 1);
                        else
                            convCount_reg <=
                                CONV_COUNT_W'(VOLT_CYCLES - 1);
                    end
                end
                SAC_CV_RUN:
                begin
                    // Select going high has no effect here.
                    if (convDone)
                        convState_reg <= SAC_CV_IDLE;
                    else
                        convCount_reg <= convCount_reg - 1'b1;
                end
            endcase
        end
    end

    // The strobe is a plain register output and never floats.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            strobe_reg <= 1'b1;
        else if (convState_reg == SAC_CV_IDLE && convEvent)
            strobe_reg <= 1'b0;
        else if (convDone)
            strobe_reg <= 1'b1;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            resultWord_reg <= RESULT_RESET;
        else if (convDone && convTemp_reg)
            resultWord_reg <= {2'b00, adcTempCode, 2'b00};
        else if (convDone)
            resultWord_reg <= {adcVoltCode[9], adcVoltCode,
                               adcSubBits[0], adcSubBits[1],
                               adcSubBits[2], 2'b00};
        else if (cfgEvent && linkPowerMode_reg == SAC_PM_SHUTDOWN)
            resultWord_reg <= RESULT_RESET;
    end

    assign conversionStrobe = strobe_reg;
    assign powerMode        = powerMode_reg;
    assign inputSelect      = inputSelect_reg;
    assign converting       = (convState_reg == SAC_CV_RUN);
    assign internalRefEn    = refSelect_reg
                           | (converting & convTemp_reg);

    // Helper state read only by the checks below.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            lowCount_reg <= '0;
        else if (strobe_reg)
            lowCount_reg <= '0;
        else
            lowCount_reg <= lowCount_reg + 1'b1;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cfgSeen_reg <= 1'b0;
        else if (cfgEvent)
            cfgSeen_reg <= 1'b1;
    end

    property p_strobe_falls;
        @(posedge clock) disable iff (!reset_n)
        (convState_reg == SAC_CV_IDLE && convEvent)
            |=> !conversionStrobe [*3];
    endproperty
    a_strobe_falls: assert property (p_strobe_falls)
        else $error("Strobe did not fall on a conversion request.");

    property p_conv_length;
        @(posedge clock) disable iff (!reset_n)
        $rose(conversionStrobe) |->
            (lowCount_reg == CONV_COUNT_W'(convTemp_reg ? TEMP_CYCLES
                                                        : VOLT_CYCLES));
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("Strobe low time differs from conversion time.");

    property p_powerup_shutdown;
        @(posedge clock) disable iff (!reset_n)
        !cfgSeen_reg |-> (powerMode == SAC_PM_SHUTDOWN);
    endproperty
    a_powerup_shutdown: assert property (p_powerup_shutdown)
        else $error("Power mode left shutdown without a setup byte.");

    property p_shutdown_clears;
        @(posedge clock) disable iff (!reset_n)
        (cfgEvent && !convDone && linkPowerMode_reg == SAC_PM_SHUTDOWN)
            |=> (resultWord_reg == RESULT_RESET)
                && (powerMode == SAC_PM_SHUTDOWN);
    endproperty
    a_shutdown_clears: assert property (p_shutdown_clears)
        else $error("Result not cleared on entering shutdown.");

    property p_temp_internal_ref;
        @(posedge clock) disable iff (!reset_n)
        (converting && convTemp_reg) |-> internalRefEn;
    endproperty
    a_temp_internal_ref: assert property (p_temp_internal_ref)
        else $error("Temperature conversion without internal reference.");

    property p_zero_tail;
        @(negedge linkClock) disable iff (!reset_n)
        (outCount_reg == OUT_COUNT_DONE) |-> (serialOut == 1'b0);
    endproperty
    a_zero_tail: assert property (p_zero_tail)
        else $error("Nonzero output after sixteen bits.");

    property p_float_when_idle;
        @(posedge clock) disable iff (!reset_n)
        chipSelectN |-> !serialOutEn;
    endproperty
    a_float_when_idle: assert property (p_float_when_idle)
        else $error("Serial output driven while select is high.");

    property p_start_bit;
        @(posedge linkClock) disable iff (!linkRst_n)
        (rxState_reg == SAC_RX_HUNT && serialIn)
            |=> (rxState_reg == SAC_RX_SHIFT) && (rxBits_reg == 3'h0);
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("Start bit not taken.");

    property p_rearm;
        @(posedge linkClock) disable iff (!linkRst_n)
        (rxState_reg == SAC_RX_HOLD && outCount_reg == OUT_COUNT_DONE
            && !convReqPos_reg) |=> (rxState_reg == SAC_RX_HUNT);
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("Start hunting not re-armed after readout.");

    property p_bad_byte;
        @(posedge linkClock) disable iff (!linkRst_n)
        (byteDone && !cfgByte && !convByte)
            |=> (rxState_reg == SAC_RX_HUNT) && $stable(linkSelect_reg)
                && $stable(linkPowerMode_reg);
    endproperty
    a_bad_byte: assert property (p_bad_byte)
        else $error("Unrecognised byte changed the settings.");

endmodule : sac_serial_adc

`default_nettype wire

// [sim/sac_host_model.sv]
// Host serial master model that drives the shift link in clock mode zero.
`timescale 1ns/1ps
`default_nettype none

module sac_host_model (
    output var  logic linkClock,
    output var  logic chipSelectN,
    output var  logic serialIn,
    input  wire logic serialOut,
    input  wire logic conversionStrobe
);
    localparam int HALF = 16;

    initial
    begin
        linkClock   = 1'b0;
        chipSelectN = 1'b0;
        serialIn    = 1'b0;
        // Select idles high only after the bench's reset edge at 1 ns, so
        // that edge also reaches the receiver's reset.
        #(2);
        chipSelectN = 1'b1;
    end

    // Released data shows the inverse of its last value, never a held copy.
    task automatic select(input logic on);
        #(HALF);
        chipSelectN = ~on;
        serialIn    = ~serialIn;
        #(HALF);
    endtask : select

    // Shifts n bits MSB first; the clock stays parked low between calls.
    task automatic shift(input int n, input logic [15:0] txd,
                         output logic [15:0] rxd);
        rxd = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            while (conversionStrobe !== 1'b1)
                #(HALF);
            serialIn = txd[i];
            #(HALF);
            rxd[i]    = serialOut;
            linkClock = 1'b1;
            #(HALF);
            linkClock = 1'b0;
        end
        #(HALF);
    endtask : shift
endmodule : sac_host_model

`default_nettype wire

// [sim/serial_adc_command_and_readout_test.sv]
// Self-checking bench for the serial ADC command and readout block.
`timescale 1ns/1ps
`default_nettype none

`define CHECK(g, e) \
    begin \
        checkCount++; \
        if ((g) !== (e)) \
        begin \
            nErrors++; \
            $display("unexpected t=%0t got %h exp %h", $time, g, e); \
        end \
    end

module serial_adc_command_and_readout_test;
    import sac_pkg::*;

    localparam int TEMP_N = 40;
    localparam int VOLT_N = 20;
    localparam logic [7:0] BAD  [3] = '{8'hC5, 8'hB3, 8'hE9};
    localparam logic [3:0] VSEL [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
                                        4'h6, 4'h8, 4'h9, 4'hB};

    logic        clock;
    logic        reset_n;
    logic        linkClock;
    logic        chipSelectN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutEn;
    logic        conversionStrobe;
    logic [11:0] adcTempCode;
    logic [9:0]  adcVoltCode;
    logic [2:0]  adcSubBits;
    logic [1:0]  powerMode;
    logic        internalRefEn;
    logic [3:0]  inputSelect;
    logic        converting;
    logic        refNow;
    logic [15:0] rx;
    int          nErrors    = 0;
    int          checkCount = 0;

    sac_serial_adc #(.TEMP_CYCLES(TEMP_N), .VOLT_CYCLES(VOLT_N))
    u_sac_serial_adc (
        .clock(clock), .reset_n(reset_n), .linkClock(linkClock),
        .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn),
        .conversionStrobe(conversionStrobe), .adcTempCode(adcTempCode),
        .adcVoltCode(adcVoltCode), .adcSubBits(adcSubBits),
        .powerMode(powerMode), .internalRefEn(internalRefEn),
        .inputSelect(inputSelect), .converting(converting));

    // A deselected output shows the host the inverse of its last value.
    sac_host_model u_sac_host_model (
        .linkClock(linkClock), .chipSelectN(chipSelectN),
        .serialIn(serialIn),
        .serialOut(serialOutEn ? serialOut : ~serialOut),
        .conversionStrobe(conversionStrobe));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic closeOut();
        if (nErrors == 0 && checkCount > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : closeOut

    function automatic logic tempSel(input logic [3:0] sel);
        return (sel == SEL_INT_DIODE) || (sel == SEL_EXT_DIODE1)
            || (sel == SEL_EXT_DIODE2);
    endfunction : tempSel

    // Temperature words carry zero lead bits; voltage words repeat the sign.
    function automatic logic [15:0] expectWord(input logic isTemp);
        if (isTemp)
            return {2'h0, adcTempCode, 2'h0};
        return {adcVoltCode[9], adcVoltCode, adcSubBits[0], adcSubBits[1],
                adcSubBits[2], 2'h0};
    endfunction : expectWord

    task automatic configure(input logic [1:0] pm, input logic rf,
                             input int lead);
        logic [15:0] got;
        refNow = rf;
        u_sac_host_model.shift(8 + lead, {8'h00, 4'h8, 1'b0, pm, rf}, got);
        repeat (8) @(negedge clock);
        `CHECK(powerMode, pm)
        `CHECK(internalRefEn, rf)
    endtask : configure

    task automatic convert(input logic [3:0] sel, input logic csPulse);
        logic [15:0] got;
        logic [15:0] want;
        logic        isTemp;
        int          n;
        isTemp = tempSel(sel);
        @(negedge clock);
        adcTempCode = 12'($urandom);
        adcVoltCode = 10'($urandom);
        adcSubBits  = 3'($urandom);
        want = expectWord(isTemp);
        u_sac_host_model.shift(8, {8'h00, 4'hA, sel}, got);
        n = 0;
        while (conversionStrobe !== 1'b0 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        `CHECK(n < 8, 1'b1)
        `CHECK(inputSelect, sel)
        `CHECK(internalRefEn, isTemp | refNow)
        n = 0;
        fork
            if (csPulse)
            begin
                u_sac_host_model.select(1'b0);
                `CHECK(serialOutEn, 1'b0)
                `CHECK(conversionStrobe, 1'b0)
                u_sac_host_model.select(1'b1);
            end
            while (conversionStrobe === 1'b0 && n < 1000)
            begin
                @(negedge clock);
                n++;
            end
        join
        `CHECK(n, isTemp ? TEMP_N : VOLT_N)
        // After a select pulse the receiver hunts, so the input stays low.
        u_sac_host_model.shift(16, csPulse ? 16'h0000 : 16'($urandom), got);
        `CHECK(got, want)
        u_sac_host_model.shift(4, 16'h0000, got);
        `CHECK(got[3:0], 4'h0)
    endtask : convert

    initial
    begin
        reset_n     = 1'b1;
        adcTempCode = 12'h000;
        adcVoltCode = 10'h000;
        adcSubBits  = 3'h0;
        refNow      = 1'b0;
        void'($urandom(32'hE2973904));
        // Reset falls just after time zero so every asynchronous reset,
        // including those of the idle shift-clock side, sees an edge.
        #1;
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        `CHECK(powerMode, 2'h0)
        `CHECK(conversionStrobe, 1'b1)
        `CHECK(serialOutEn, 1'b0)
        u_sac_host_model.select(1'b1);
        `CHECK(serialOutEn, 1'b1)
        for (int pm = 0; pm < 4; pm++)
            configure(2'(pm), 1'($urandom), 3'($urandom));
        for (int i = 0; i < 3; i++)
        begin
            u_sac_host_model.shift(8, {8'h00, BAD[i]}, rx);
            repeat (8) @(negedge clock);
            `CHECK(powerMode, 2'h3)
            `CHECK(converting, 1'b0)
        end
        convert(VSEL[$urandom_range(8)], 1'b1);
        convert(SEL_INT_DIODE, 1'b0);
        convert(SEL_EXT_DIODE1, 1'b1);
        convert(SEL_EXT_DIODE2, 1'b0);
        `CHECK(powerMode, 2'h3)
        for (int i = 0; i < 4; i++)
        begin
            configure(2'(3 - i), 1'($urandom), 0);
            convert(VSEL[$urandom_range(8)], 1'b0);
        end
        closeOut();
    end

    initial
    begin
        #100000;
        nErrors++;
        closeOut();
    end
endmodule : serial_adc_command_and_readout_test

`default_nettype wire
